// ### rtl/vid_in_pkg.sv
package vid_in_pkg;

	// Synchronised pin bundle, all pins pass two flip-flops.
	typedef struct packed {
		logic pclk;
		logic line_sync;
		logic frame_sync;
		logic pixel_valid;
		logic [23:0] din;
		logic [2:0] aud;
		logic power_down_n;
		logic freq_mode;
		logic [1:0] mode_strap;
		logic [2:0] addr_strap;
		logic scl;
		logic sda;
	} pins_t;

	// Control settings, held at reset while powered down.
	typedef struct packed {
		logic edge_sel;
		logic filt_en;
		logic gpio_en;
		logic [3:0] gpio_dir;
		logic [3:0] gpio_lvl;
		logic [8:4] gpo_en;
		logic [8:4] gpo_lvl;
	} cfg_t;

	localparam int WORD_W = 30;
	localparam int FIFO_DEPTH = 8;
	localparam int SHARED_W = 6;
	localparam logic [1:0] FILTER_MIN_PCLKS = 2'h3;
	localparam logic [1:0] FILTER_CNT_RESET = 2'h0;
	localparam int STRAP_COLOR18_BIT = 0;
	localparam int STRAP_GPIO_BIT = 1;
	localparam int GPO_DIN16 = 4;
	localparam int GPO_DIN17 = 5;
	localparam int GPO_AUD_DA = 6;
	localparam int GPO_AUD_WS = 7;
	localparam int GPO_AUD_CLK = 8;
	localparam cfg_t CFG_RESET = '{
		edge_sel: 1'b0,
		filt_en: 1'b1,
		gpio_en: 1'b0,
		gpio_dir: 4'h0,
		gpio_lvl: 4'h0,
		gpo_en: 5'h00,
		gpo_lvl: 5'h00
	};
	// Address per divider level; values are arbitrary.
	localparam logic [6:0] BUS_ADDR_BASE = 7'h20;
	localparam logic [6:0] BUS_ADDR_STEP = 7'h01;

	function automatic logic [6:0] strap_to_addr(input logic [2:0] level);
		return BUS_ADDR_BASE + BUS_ADDR_STEP * {4'h0, level};
	endfunction

endpackage

// ### rtl/stream_if.sv
`timescale 1ns/10ps
interface stream_if #(parameter int W = 30);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	modport fifo(input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data);
	modport user(output wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data);
endinterface

// ### rtl/pixel_fifo.sv
`timescale 1ns/10ps
module pixel_fifo #(
	parameter int W = 30,
	parameter int D = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Both sides of the buffer
	stream_if.fifo s
);
	// Depth must be a power of two for the wrap-bit full test.
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fifo_state_t;

	fifo_state_t st;
	fifo_state_t next_st;
	logic full;
	logic empty;

	assign empty = st.wp == st.rp;
	assign full = (st.wp[AW] != st.rp[AW]) &&
		(st.wp[AW-1:0] == st.rp[AW-1:0]);
	assign s.wr_ready = !full;
	assign s.rd_valid = !empty;
	assign s.rd_data = st.mem[st.rp[AW-1:0]];

	always_comb begin
		next_st = st;
		if (s.wr_valid && !full) begin
			next_st.mem[st.wp[AW-1:0]] = s.wr_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (s.rd_ready && !empty) begin
			next_st.rp = st.rp + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	chk_fifo_fill_bound: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) (st.wp - st.rp) <= (AW+1)'(D))
		else $error("fifo holds more words than its depth");

endmodule // pixel_fifo

// ### rtl/video_input_port.sv
// Operation
// - With the filter on, a line-sync or pixel-valid pulse goes on only if it spans three pixel clocks.
// - With the filter off, line-sync and pixel-valid changes go on with no minimum width.
// - Video inputs are sampled on the pixel-clock edge picked by the edge select setting.
// - Each audio input pin may instead be a setting-driven output, and may be left open.
// - Four two-way general lines replace pixel bits 9, 8, 1 and 0, only in 18-bit mode.
// - Setting-driven outputs share the audio pins and pixel bits 17 and 16.
// - With the power-down input high the block runs normally.
// - With power-down low, both link outputs sit high, the PLL stops, settings hold reset.
// - The frequency mode input selects the intermediate-frequency coax mode.
// - The configuration strap picks colour depth and pin sharing.
// - The management address comes from the level of the address strap.
// - Management clock and data are open-drain: only ever driven low.
// - Pixel bits 16 and 17 may serve as setting-driven outputs four and five.
`timescale 1ns/10ps
module video_input_port (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	// Video pins
	input wire logic PCLK_IN,
	input wire logic LINE_SYNC_IN,
	input wire logic FRAME_SYNC_IN,
	input wire logic PIXEL_VALID_IN,
	input wire logic [23:0] DIN_IN,
	input wire logic [2:0] AUDIO_IN,
	// Shared pin drivers, order {17,16,9,8,1,0} and {clk,ws,da}
	output logic [5:0] SHARED_DIN_OUT,
	output logic [5:0] SHARED_DIN_OE_OUT,
	output logic [2:0] AUDIO_OUT,
	output logic [2:0] AUDIO_OE_OUT,
	// Control pins and straps
	input wire logic POWER_DOWN_N_IN,
	input wire logic FREQ_MODE_SELECT_IN,
	input wire logic [1:0] MODE_STRAP_IN,
	input wire logic [2:0] BUS_ADDRESS_STRAP_IN,
	// Settings
	input wire logic SAMPLE_EDGE_SELECT_IN,
	input wire logic FILTER_EN_IN,
	input wire logic GPIO_EN_IN,
	input wire logic [3:0] GPIO_DIR_IN,
	input wire logic [3:0] GPIO_LEVEL_IN,
	input wire logic [8:4] REG_DRIVEN_EN_IN,
	input wire logic [8:4] REG_DRIVEN_OUTPUTS_IN,
	// Status
	output logic [3:0] GPIO_PIN_LEVEL_OUT,
	output logic COLOR18_OUT,
	output logic [6:0] BUS_ADDR_OUT,
	output logic STRAP_VALID_OUT,
	output logic IF_MODE_OUT,
	output logic PLL_EN_OUT,
	output logic OVERFLOW_OUT,
	// Link outputs
	input wire logic LINK_BIT_IN,
	output logic LINK_P_OUT,
	output logic LINK_N_OUT,
	// Management bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SCL_OUT,
	output logic SCL_OE_OUT,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic MGMT_SCL_LOW_IN,
	input wire logic MGMT_SDA_LOW_IN,
	output logic MGMT_SCL_OUT,
	output logic MGMT_SDA_OUT,
	// Captured video words
	output logic VIDEO_VALID_OUT,
	input wire logic VIDEO_READY_IN,
	output logic [vid_in_pkg::WORD_W-1:0] VIDEO_WORD_OUT,
	output logic FIFO_READY_OUT
);
	typedef struct packed {
		vid_in_pkg::pins_t s1;
		vid_in_pkg::pins_t s2;
		logic pclk_prev;
		logic line_fwd;
		logic valid_fwd;
		logic [1:0] line_cnt;
		logic [1:0] valid_cnt;
		logic [1:0][27:0] dly;
		vid_in_pkg::cfg_t cfg;
		logic strap_done;
		logic [1:0] mode;
		logic [6:0] bus_addr;
		logic overflow;
		logic if_mode;
		logic pll_en;
		logic link_p;
		logic link_n;
		logic scl_low;
		logic sda_low;
		logic [5:0] din_out;
		logic [5:0] din_oe;
		logic [2:0] aud_out;
		logic [2:0] aud_oe;
	} state_t;

	state_t st;
	state_t next_st;
	vid_in_pkg::pins_t pins;
	vid_in_pkg::cfg_t cfg_in;
	logic pix_edge;
	logic run;
	logic gpio_active;
	logic [27:0] raw_rest;
	logic [27:0] rest;
	logic [vid_in_pkg::WORD_W-1:0] word;
	logic [1:0] gpio_pin;
	logic [2:0] line_step;
	logic [2:0] valid_step;
	stream_if #(.W(vid_in_pkg::WORD_W)) buf_if ();

	// Returns {forwarded level, run count} after one pixel sample.
	function automatic logic [2:0] filter_step(input logic raw,
		input logic fwd, input logic en, input logic [1:0] cnt);
		if (!en || raw == fwd) begin
			return {raw, vid_in_pkg::FILTER_CNT_RESET};
		end
		if (cnt == vid_in_pkg::FILTER_MIN_PCLKS - 2'h1) begin
			return {raw, vid_in_pkg::FILTER_CNT_RESET};
		end
		return {fwd, cnt + 2'h1};
	endfunction

	assign pins = '{
		pclk: PCLK_IN,
		line_sync: LINE_SYNC_IN,
		frame_sync: FRAME_SYNC_IN,
		pixel_valid: PIXEL_VALID_IN,
		din: DIN_IN,
		aud: AUDIO_IN,
		power_down_n: POWER_DOWN_N_IN,
		freq_mode: FREQ_MODE_SELECT_IN,
		mode_strap: MODE_STRAP_IN,
		addr_strap: BUS_ADDRESS_STRAP_IN,
		scl: SCL_IN,
		sda: SDA_IN
	};
	assign cfg_in = '{
		edge_sel: SAMPLE_EDGE_SELECT_IN,
		filt_en: FILTER_EN_IN,
		gpio_en: GPIO_EN_IN,
		gpio_dir: GPIO_DIR_IN,
		gpio_lvl: GPIO_LEVEL_IN,
		gpo_en: REG_DRIVEN_EN_IN,
		gpo_lvl: REG_DRIVEN_OUTPUTS_IN
	};

	// The pixel clock is oversampled, so it must stay below half the
	// core rate; faster pixel clocks lose edges.
	assign pix_edge = (st.s2.pclk != st.pclk_prev) &&
		(st.s2.pclk == !st.cfg.edge_sel);
	assign run = st.s2.power_down_n;
	assign gpio_active = st.mode[vid_in_pkg::STRAP_COLOR18_BIT] &&
		(st.mode[vid_in_pkg::STRAP_GPIO_BIT] || st.cfg.gpio_en);

	// Pixel bits lent to other roles are sent as zero.
	always_comb begin
		raw_rest = {st.s2.frame_sync, st.s2.din, st.s2.aud};
		if (gpio_active) begin
			raw_rest[12:11] = 2'h0;
			raw_rest[4:3] = 2'h0;
		end
		if (st.cfg.gpo_en[vid_in_pkg::GPO_DIN16]) begin
			raw_rest[19] = 1'b0;
		end
		if (st.cfg.gpo_en[vid_in_pkg::GPO_DIN17]) begin
			raw_rest[20] = 1'b0;
		end
		raw_rest[2:0] = raw_rest[2:0] & ~st.cfg.gpo_en[8:6];
	end

	// The filter holds syncs back two samples, so the rest is aligned.
	assign rest = st.cfg.filt_en ? st.dly[1] : raw_rest;
	assign line_step = filter_step(st.s2.line_sync, st.line_fwd,
		st.cfg.filt_en, st.line_cnt);
	assign valid_step = filter_step(st.s2.pixel_valid, st.valid_fwd,
		st.cfg.filt_en, st.valid_cnt);
	assign word = {line_step[2], valid_step[2], rest};
	assign buf_if.wr_valid = pix_edge && run;
	assign buf_if.wr_data = word;
	assign buf_if.rd_ready = VIDEO_READY_IN;

	always_comb begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.pclk_prev = st.s2.pclk;
		next_st.if_mode = st.s2.freq_mode && run;
		next_st.pll_en = run;
		next_st.link_p = run ? LINK_BIT_IN : 1'b1;
		next_st.link_n = run ? !LINK_BIT_IN : 1'b1;
		next_st.scl_low = MGMT_SCL_LOW_IN;
		next_st.sda_low = MGMT_SDA_LOW_IN;
		next_st.cfg = run ? cfg_in : vid_in_pkg::CFG_RESET;
		if (!run) begin
			next_st.strap_done = 1'b0;
			next_st.overflow = 1'b0;
		end else if (!st.strap_done) begin
			next_st.strap_done = 1'b1;
			next_st.mode = st.s2.mode_strap;
			next_st.bus_addr = vid_in_pkg::strap_to_addr(
				st.s2.addr_strap);
		end
		if (pix_edge && run) begin
			{next_st.line_fwd, next_st.line_cnt} = line_step;
			{next_st.valid_fwd, next_st.valid_cnt} = valid_step;
			next_st.dly = {st.dly[0], raw_rest};
			if (!buf_if.wr_ready) begin
				next_st.overflow = 1'b1;
			end
		end
		// GPIO order {3,2,1,0} sits on din bits {9,8,1,0}.
		next_st.din_oe[3:0] = gpio_active ? st.cfg.gpio_dir : 4'h0;
		next_st.din_out[3:0] = st.cfg.gpio_lvl;
		next_st.din_oe[5:4] = st.cfg.gpo_en[5:4];
		next_st.din_out[5:4] = st.cfg.gpo_lvl[5:4];
		// Audio pins in order {clk, ws, da} map to outputs 8, 7, 6.
		next_st.aud_oe = st.cfg.gpo_en[8:6];
		next_st.aud_out = st.cfg.gpo_lvl[8:6];
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			st <= '0;
			st.cfg <= vid_in_pkg::CFG_RESET;
			st.link_p <= 1'b1;
			st.link_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	pixel_fifo #(
		.W(vid_in_pkg::WORD_W),
		.D(vid_in_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(ARST_N_IN),
		.s(buf_if)
	);

	assign gpio_pin = {st.s2.din[9], st.s2.din[8]};
	assign GPIO_PIN_LEVEL_OUT = {gpio_pin, st.s2.din[1], st.s2.din[0]};
	assign SHARED_DIN_OUT = st.din_out;
	assign SHARED_DIN_OE_OUT = st.din_oe;
	assign AUDIO_OUT = st.aud_out;
	assign AUDIO_OE_OUT = st.aud_oe;
	assign COLOR18_OUT = st.mode[vid_in_pkg::STRAP_COLOR18_BIT];
	assign BUS_ADDR_OUT = st.bus_addr;
	assign STRAP_VALID_OUT = st.strap_done;
	assign IF_MODE_OUT = st.if_mode;
	assign PLL_EN_OUT = st.pll_en;
	assign OVERFLOW_OUT = st.overflow;
	assign LINK_P_OUT = st.link_p;
	assign LINK_N_OUT = st.link_n;
	// Open-drain: the pad value is always low, only the enable moves.
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE_OUT = st.scl_low;
	assign SDA_OE_OUT = st.sda_low;
	assign MGMT_SCL_OUT = st.s2.scl;
	assign MGMT_SDA_OUT = st.s2.sda;
	assign VIDEO_VALID_OUT = buf_if.rd_valid;
	assign VIDEO_WORD_OUT = buf_if.rd_data;
	assign FIFO_READY_OUT = buf_if.wr_ready;

	chk_filter_min_width: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		(st.line_fwd != $past(st.line_fwd)) && $past(st.cfg.filt_en)
		|-> $past(st.line_cnt) == 2'h2)
		else $error("line sync forwarded before three samples");

	chk_filter_bypass: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		pix_edge && run && !st.cfg.filt_en
		|=> st.valid_fwd == $past(st.s2.pixel_valid))
		else $error("pixel valid delayed with filter off");

	chk_edge_select: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		buf_if.wr_valid |-> st.s2.pclk != st.cfg.edge_sel &&
		st.pclk_prev == st.cfg.edge_sel)
		else $error("sample taken on the wrong pixel clock edge");

	chk_audio_as_out: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		run && st.cfg.gpo_en[8] |=> AUDIO_OE_OUT[2] &&
		AUDIO_OUT[2] == $past(st.cfg.gpo_lvl[8]))
		else $error("audio clock pin not driven as output");

	chk_gpio_18bit: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		SHARED_DIN_OE_OUT[3:0] != 4'h0 |-> $past(gpio_active))
		else $error("general line driven outside 18-bit mode");

	chk_din16_output: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		st.cfg.gpo_en[4] ##1 st.cfg.gpo_en[4] |-> SHARED_DIN_OE_OUT[4] &&
		SHARED_DIN_OUT[4] == $past(st.cfg.gpo_lvl[4]) &&
		(buf_if.wr_data[19] == 1'b0 || st.cfg.filt_en))
		else $error("pixel bit 16 not serving as output four");

	chk_power_down: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		!run |=> LINK_P_OUT && LINK_N_OUT && !PLL_EN_OUT &&
		st.cfg == vid_in_pkg::CFG_RESET)
		else $error("power-down state not held");

	chk_normal_run: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		run [*2] |-> PLL_EN_OUT && STRAP_VALID_OUT)
		else $error("block not running with power-down released");

	chk_if_mode: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		run && st.s2.freq_mode |=> IF_MODE_OUT)
		else $error("intermediate frequency mode not entered");

	chk_strap_addr: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		$rose(STRAP_VALID_OUT) |-> BUS_ADDR_OUT ==
		vid_in_pkg::strap_to_addr($past(st.s2.addr_strap)))
		else $error("bus address does not follow the strap");

	chk_open_drain: assert property (@(posedge CORE_CLK_IN)
		disable iff (!ARST_N_IN)
		(!SCL_OUT && !SDA_OUT) and (MGMT_SDA_LOW_IN |=> SDA_OE_OUT))
		else $error("management line driven high");

endmodule // video_input_port

// ### bench/video_source.sv
`timescale 1ns/10ps
module video_source (
	// Control from the bench
	input wire logic run_in,
	input wire logic edge_sel_in,
	input wire logic [7:0] plen_in,
	// Video pins
	output logic pclk_out,
	output logic line_out,
	output logic frame_out,
	output logic valid_out,
	output logic [23:0] din_out,
	output logic [2:0] aud_out
);
	int cnt = 0;
	// The pixel clock parks low between runs; its phase drifts against the core.
	initial begin
		{pclk_out, line_out, frame_out, valid_out, din_out, aud_out} = '0;
		forever begin
			#31.3;
			if (run_in || pclk_out) begin
				pclk_out = ~pclk_out;
			end
		end
	end
	// Pins move on the edge opposite the sampling edge, so they are stable there.
	always @(pclk_out) begin
		if (pclk_out == edge_sel_in) begin
			cnt++;
			line_out <= cnt % 140 >= 10 && cnt % 140 < 10 + plen_in;
			valid_out <= cnt % 140 >= 70 && cnt % 140 < 70 + plen_in;
			frame_out <= (cnt % 200 == 100) ? ~frame_out : frame_out;
			din_out <= 24'($urandom);
			aud_out <= 3'($urandom);
		end
	end
endmodule // video_source

// ### bench/video_input_port_tb_top.sv
`timescale 1ns/10ps
module video_input_port_tb_top;
	logic clk = 0, arst_n = 0, pd_n = 1, freq_mode_select = 0, esel = 0, filt = 1;
	logic gen = 0, lbit = 0, ready = 0, run = 0, m_scl = 0, m_sda = 0;
	logic [1:0] strap = 0, ext_low = 0;
	logic [2:0] addr = 0;
	logic [3:0] gdir = 0, glvl = 0;
	logic [8:4] oen = 0, olvl = 0;
	logic [7:0] plen = 2;
	logic pclk, ls, fs, pv, scl_oe, sda_oe;
	logic [23:0] din;
	logic [2:0] aud, aud_o, aud_oe;
	logic [5:0] sh_o, sh_oe;
	logic [3:0] gpin;
	logic [6:0] baddr;
	logic c18, sval, ifm, pll, ovf, lp, ln, scl_o, sda_o, mscl, msda, vv, fr;
	logic [vid_in_pkg::WORD_W-1:0] word;
	logic [29:0] h0, h1, h2, w;
	logic [29:0] q[$];
	logic fl, fv;
	int error_cnt = 0, checks_done = 0, cap = 1000, cyc = 0;

	initial begin
		forever #4 clk = ~clk;
	end

	video_source video_source_inst (.run_in(run), .edge_sel_in(esel),
		.plen_in(plen), .pclk_out(pclk), .line_out(ls), .frame_out(fs),
		.valid_out(pv), .din_out(din), .aud_out(aud));

	video_input_port video_input_port_inst (.CORE_CLK_IN(clk),
		.ARST_N_IN(arst_n), .PCLK_IN(pclk), .LINE_SYNC_IN(ls),
		.FRAME_SYNC_IN(fs), .PIXEL_VALID_IN(pv), .DIN_IN(din), .AUDIO_IN(aud),
		.SHARED_DIN_OUT(sh_o), .SHARED_DIN_OE_OUT(sh_oe), .AUDIO_OUT(aud_o),
		.AUDIO_OE_OUT(aud_oe), .POWER_DOWN_N_IN(pd_n),
		.FREQ_MODE_SELECT_IN(freq_mode_select), .MODE_STRAP_IN(strap),
		.BUS_ADDRESS_STRAP_IN(addr), .SAMPLE_EDGE_SELECT_IN(esel),
		.FILTER_EN_IN(filt), .GPIO_EN_IN(gen), .GPIO_DIR_IN(gdir),
		.GPIO_LEVEL_IN(glvl), .REG_DRIVEN_EN_IN(oen),
		.REG_DRIVEN_OUTPUTS_IN(olvl), .GPIO_PIN_LEVEL_OUT(gpin),
		.COLOR18_OUT(c18), .BUS_ADDR_OUT(baddr), .STRAP_VALID_OUT(sval),
		.IF_MODE_OUT(ifm), .PLL_EN_OUT(pll), .OVERFLOW_OUT(ovf),
		.LINK_BIT_IN(lbit), .LINK_P_OUT(lp), .LINK_N_OUT(ln),
		.SCL_IN(~(scl_oe | ext_low[0])), .SDA_IN(~(sda_oe | ext_low[1])),
		.SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_OUT(sda_o),
		.SDA_OE_OUT(sda_oe), .MGMT_SCL_LOW_IN(m_scl), .MGMT_SDA_LOW_IN(m_sda),
		.MGMT_SCL_OUT(mscl), .MGMT_SDA_OUT(msda), .VIDEO_VALID_OUT(vv),
		.VIDEO_READY_IN(ready), .VIDEO_WORD_OUT(word), .FIFO_READY_OUT(fr));

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			complete_run();
		end
	end

	// Reference: one word per sampling edge, filtered syncs lag two samples.
	always @(pclk) begin
		if (pclk != esel) begin
			h2 = h1;
			h1 = h0;
			h0 = {ls, pv, fs, din, aud};
			if (h2[29] == h1[29] && h1[29] == h0[29]) fl = h0[29];
			if (h2[28] == h1[28] && h1[28] == h0[28]) fv = h0[28];
			w = filt ? {fl, fv, h2[27:0]} : h0;
			if (q.size() < cap) q.push_back(w);
		end
	end

	always @(posedge clk) begin
		if (arst_n && vv === 1'b1 && ready) begin
			if (q.size() == 0) check("extra word", 32'h1, 32'h0);
			else check("word", 32'(word), 32'(q.pop_front()));
		end
	end

	task automatic do_reset();
		arst_n = 0;
		repeat (8) @(negedge clk);
		arst_n = 1;
		repeat (8) @(negedge clk);
		{h0, h1, h2, fl, fv} = '0;
		q.delete();
	endtask

	task automatic stream(logic f, logic e, int p, logic stall);
		@(negedge clk);
		{filt, esel, plen} = {f, e, 8'(p)};
		do_reset();
		cap = stall ? vid_in_pkg::FIFO_DEPTH : 1000;
		run = 1;
		repeat (stall ? 160 : 2400) begin
			@(negedge clk);
			ready = stall ? 1'b0 : ($urandom % 4 != 0);
			lbit = 1'($urandom);
		end
		run = 0;
		repeat (40) @(negedge clk);
		if (stall) begin
			check("overflow", 32'(ovf), 32'h1);
			check("fifo ready", 32'(fr), 32'h0);
		end
		ready = 1;
		repeat (30) @(negedge clk);
		check("words left", 32'(q.size()), 32'h0);
		check("valid idle", 32'(vv), 32'h0);
	endtask

	initial begin
		logic a;
		void'($urandom(61));
		do_reset();
		// Straps, shared pins and setting-driven outputs.
		for (int m = 0; m < 4; m++) begin
			{strap, addr, gen, glvl, olvl} = {2'(m), 3'($urandom),
				1'($urandom), 4'($urandom), 5'($urandom)};
			{gdir, oen} = {4'hf, 5'h1f};
			a = strap[0] && (strap[1] || gen);
			do_reset();
			check("color18", 32'(c18), 32'(strap[0]));
			check("strap valid", 32'(sval), 32'h1);
			check("addr", 32'(baddr), 32'(vid_in_pkg::BUS_ADDR_BASE +
				vid_in_pkg::BUS_ADDR_STEP * addr));
			check("shared oe", 32'(sh_oe), 32'({2'h3, a ? 4'hf : 4'h0}));
			check("shared out", 32'(sh_o & sh_oe),
				32'({olvl[5:4], glvl} & {2'h3, a ? 4'hf : 4'h0}));
			check("audio oe", 32'(aud_oe), 32'h7);
			check("audio out", 32'(aud_o), 32'(olvl[8:6]));
			{gdir, oen} = '0;
			repeat (6) @(negedge clk);
			check("inputs oe", 32'({sh_oe, aud_oe}), 32'h0);
			check("gpio in", 32'(gpin), 32'({din[9:8], din[1:0]}));
		end
		strap = 0;
		stream(0, 0, 2, 0);
		stream(0, 1, 1, 0);
		stream(1, 0, 2, 0);
		stream(1, 1, 3, 0);
		stream(0, 0, 3, 1);
		// Frequency mode, link drive and open-drain management lines.
		for (int i = 0; i < 4; i++) begin
			{freq_mode_select, lbit, m_scl, m_sda, ext_low} = {i[0], 1'($urandom), i[0],
				i[1], i[0], i[1]};
			repeat (5) @(negedge clk);
			check("if mode", 32'(ifm), 32'(i[0]));
			check("link", 32'({lp, ln, pll}), 32'({lbit, ~lbit, 1'b1}));
			check("od drive", 32'({scl_o, sda_o, scl_oe, sda_oe}),
				32'({2'h0, i[0], i[1]}));
			check("od level", 32'({mscl, msda}), 32'({2{~(i[0] | i[1])}}));
		end
		{pd_n, oen} = {1'b0, 5'h1f};
		repeat (6) @(negedge clk);
		check("power down", 32'({lp, ln, pll, ovf, sval, aud_oe}), 32'hc0);
		pd_n = 1;
		repeat (8) @(negedge clk);
		check("power up", 32'({pll, sval, aud_oe}), 32'h1f);
		complete_run();
	end
endmodule // video_input_port_tb_top
